/* File: logic/phy_base_registers.sv */
/*
  Base register bank of a cable PHY behind an Avalon-MM slave with
  waitrequest. Sixteen 8-bit registers, eight base and eight paged.
  Assumes the PHY core gives its status and events as synchronous
  single-cycle strobes and levels on this clock.
*/
// The implementer's own choice: the Avalon-MM interface to the registers.
module phy_base_registers (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic busResetSeen,
  input wire logic selfIdDone,
  input wire logic [5:0] selfIdNode,
  input wire logic becameRoot,
  input wire logic cable_power_sense,
  input wire logic dual_port_strap,
  input wire logic [2:0] power_class_straps,
  input wire logic contenderStrap,
  input wire logic link_power_status,
  input wire logic linkBusy,
  input wire logic configGapValid,
  input wire logic [5:0] configGap,
  input wire logic configTimeout,
  input wire logic stateTimeout,
  input wire logic portEvent,
  input wire logic resumeStart,
  output logic [5:0] gapCount,
  output logic rootHoldoff,
  output logic linkActiveFlag,
  output logic nodeIdValid,
  output logic statusPush,
  output logic [7:0] statusData,
  output logic busResetDrive,
  output logic busResetShort,
  output logic arbAccelEnable
);
  logic [3:0] regIndex;
  logic ackCycle;
  logic wrStrobe;
  logic [7:0] wrByte;
  logic busReset;
  logic [5:0] nodeId_q;
  logic root_q;
  logic holdoff_q;
  logic longReq_q;
  logic shortReq_q;
  logic [5:0] gap_q;
  logic [1:0] stale_q;
  logic linkCtrl_q;
  logic contender_q;
  logic [2:0] powerClass_q;
  logic resumeIrqEn_q;
  logic accel_q;
  logic multiEn_q;
  logic [2:0] page_q;
  logic [3:0] portSel_q;
  logic cpsPrev_q;
  logic strapLoad_q;
  logic timerActive;
  logic timerStart;
  logic [phy_regs_pkg::NUM_FLAGS-1:0] flagSet;
  logic [phy_regs_pkg::NUM_FLAGS-1:0] flags;

  // Register index from a byte address; one register per aligned word
  function automatic logic [3:0] reg_index(input logic [5:0] addr);
    return addr[5:phy_regs_pkg::IDX_LSB];
  endfunction

  function automatic logic write_hits(input logic we, input logic [3:0] idx,
                                      input logic [3:0] want);
    return we && (idx == want);
  endfunction

  assign regIndex = reg_index(address);
  assign ackCycle = !waitrequest && (read || write);
  assign wrStrobe = ackCycle && write && byteenable[0];
  assign wrByte = writedata[7:0];
  // A bus reset is one seen on the cable or the start of one we drive
  assign busReset = busResetSeen || timerStart;

  // One wait state on every access, then the answer for one cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(waitrequest && (read || write));
    end
  end

  // Read mux; reserved, paged and unmapped locations read zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      readdata <= '0;
    end else if (waitrequest && read) begin
      readdata <= '0;
      if (address[1:0] == 2'h0) begin
        unique case (regIndex)
          phy_regs_pkg::REG_NODE:
            readdata[7:0] <= {nodeId_q, root_q, cable_power_sense};
          phy_regs_pkg::REG_GAP:
            readdata[7:0] <= {holdoff_q, longReq_q, gap_q};
          phy_regs_pkg::REG_EXT:
            readdata[7:0] <= {phy_regs_pkg::EXT_SET, 1'b0,
              dual_port_strap ? phy_regs_pkg::PORTS_TWO : phy_regs_pkg::PORTS_ONE};
          phy_regs_pkg::REG_SPEED:
            readdata[7:0] <= {phy_regs_pkg::SPEED_S400, 1'b0,
              phy_regs_pkg::DELAY_CODE};
          phy_regs_pkg::REG_LINK:
            readdata[7:0] <= {linkCtrl_q, contender_q, phy_regs_pkg::JITTER_CODE,
              powerClass_q};
          phy_regs_pkg::REG_IRQ:
            readdata[7:0] <= {resumeIrqEn_q, shortReq_q, flags, accel_q, multiEn_q};
          phy_regs_pkg::REG_PAGE:
            readdata[7:0] <= {page_q, 1'b0, portSel_q};
          // Paged window: pages 2..6 reserved, others carry no fields here
          default: readdata <= '0;
        endcase
      end
    end
  end

  // Node id learnt at self-ID; invalid from bus reset until then
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      nodeId_q <= '0;
      nodeIdValid <= 1'b0;
    end else if (busReset) begin
      nodeIdValid <= 1'b0;
    end else if (selfIdDone) begin
      nodeId_q <= selfIdNode;
      nodeIdValid <= 1'b1;
    end
  end

  // Unsolicited register 0 status transfer at self-ID completion
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      statusPush <= 1'b0;
      statusData <= '0;
    end else begin
      statusPush <= selfIdDone && !busReset;
      statusData <= {selfIdNode, root_q, cable_power_sense};
    end
  end

  // Root flag; a bus reset wins over tree-ID in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      root_q <= 1'b0;
    end else if (busReset) begin
      root_q <= 1'b0;
    end else if (becameRoot) begin
      root_q <= 1'b1;
    end
  end

  // Root holdoff only touched by hardware reset and writes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      holdoff_q <= 1'b0;
    end else if (write_hits(wrStrobe, regIndex, phy_regs_pkg::REG_GAP)) begin
      holdoff_q <= wrByte[phy_regs_pkg::BIT_HOLDOFF];
    end
  end

  // Reset requests; cleared by any bus reset, including our own start
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      longReq_q <= 1'b0;
      shortReq_q <= 1'b0;
    end else if (busReset) begin
      longReq_q <= 1'b0;
      shortReq_q <= 1'b0;
    end else begin
      if (write_hits(wrStrobe, regIndex, phy_regs_pkg::REG_GAP)) begin
        longReq_q <= wrByte[phy_regs_pkg::BIT_LONGRST];
      end
      if (write_hits(wrStrobe, regIndex, phy_regs_pkg::REG_IRQ)) begin
        shortReq_q <= wrByte[phy_regs_pkg::BIT_SHORTRST];
      end
    end
  end

  // Wait for traffic to finish; a long request outranks a short one
  assign timerStart = (longReq_q || shortReq_q) && !linkBusy && !timerActive;

  bus_reset_timer resetTimer (
    .clock(clock),
    .rst_n(rst_n),
    .start(timerStart),
    .isShort(!longReq_q),
    .active_q(timerActive)
  );

  // Drive flags for the line logic, registered
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busResetDrive <= 1'b0;
      busResetShort <= 1'b0;
    end else begin
      busResetDrive <= timerActive;
      if (timerStart) begin
        busResetShort <= !longReq_q;
      end
    end
  end

  // Gap count: write or config packet updates it and clears staleness
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gap_q <= phy_regs_pkg::GAP_RESET;
      stale_q <= '0;
    end else if (write_hits(wrStrobe, regIndex, phy_regs_pkg::REG_GAP)) begin
      gap_q <= wrByte[5:0];
      stale_q <= '0;
    end else if (configGapValid) begin
      gap_q <= configGap;
      stale_q <= '0;
    end else if (busReset) begin
      if (stale_q + 2'h1 == phy_regs_pkg::STALE_LIMIT) begin
        gap_q <= phy_regs_pkg::GAP_RESET;
        stale_q <= '0;
      end else begin
        stale_q <= stale_q + 2'h1;
      end
    end
  end

  // Registered copies the arbitration timers use, and link active control gated by link power status
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gapCount <= phy_regs_pkg::GAP_RESET;
      rootHoldoff <= 1'b0;
      arbAccelEnable <= 1'b0;
      linkActiveFlag <= 1'b0;
    end else begin
      gapCount <= gap_q;
      rootHoldoff <= holdoff_q;
      arbAccelEnable <= accel_q;
      linkActiveFlag <= linkCtrl_q && link_power_status;
    end
  end

  // Straps are caught on the first clock after reset release
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      strapLoad_q <= 1'b1;
    end else begin
      strapLoad_q <= 1'b0;
    end
  end

  // Link control, contender and power class survive bus resets
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      linkCtrl_q <= 1'b1;
      contender_q <= 1'b0;
      powerClass_q <= '0;
    end else if (strapLoad_q) begin
      contender_q <= contenderStrap;
      powerClass_q <= power_class_straps;
    end else if (write_hits(wrStrobe, regIndex, phy_regs_pkg::REG_LINK)) begin
      linkCtrl_q <= wrByte[phy_regs_pkg::BIT_LINK_ACTIVE_CONTROL];
      contender_q <= wrByte[phy_regs_pkg::BIT_CONTEND];
      powerClass_q <= wrByte[2:0];
    end
  end

  // Enables in the interrupt register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      resumeIrqEn_q <= 1'b0;
      accel_q <= 1'b0;
      multiEn_q <= 1'b0;
    end else if (write_hits(wrStrobe, regIndex, phy_regs_pkg::REG_IRQ)) begin
      resumeIrqEn_q <= wrByte[phy_regs_pkg::BIT_RPIE];
      accel_q <= wrByte[phy_regs_pkg::BIT_EAA];
      multiEn_q <= wrByte[phy_regs_pkg::BIT_EMC];
    end
  end

  // Page select and port select
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      page_q <= '0;
      portSel_q <= '0;
    end else if (write_hits(wrStrobe, regIndex, phy_regs_pkg::REG_PAGE)) begin
      page_q <= wrByte[7:5];
      portSel_q <= wrByte[3:0];
    end
  end

  // Falling edge of cable power raises the power drop flag
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cpsPrev_q <= 1'b1;
    end else begin
      cpsPrev_q <= cable_power_sense;
    end
  end

  assign flagSet[phy_regs_pkg::FLAG_CTO] = configTimeout;
  assign flagSet[phy_regs_pkg::FLAG_PWR] = cpsPrev_q && !cable_power_sense;
  assign flagSet[phy_regs_pkg::FLAG_STO] = stateTimeout;
  assign flagSet[phy_regs_pkg::FLAG_PORT] = portEvent || (resumeStart && resumeIrqEn_q);

  // Write-one-to-clear flags, one per bit
  for (genvar i = 0; i < phy_regs_pkg::NUM_FLAGS; i++) begin : gFlag
    sticky_flag #(
      .RESET_VALUE(phy_regs_pkg::FLAG_RESET[i])
    ) flagBit (
      .clock(clock),
      .rst_n(rst_n),
      .setEvent(flagSet[i]),
      .clearStrobe(write_hits(wrStrobe, regIndex, phy_regs_pkg::REG_IRQ) &&
                   wrByte[phy_regs_pkg::BIT_CONFIG_TIMEOUT_FLAG - phy_regs_pkg::FLAG_CTO + i]),
      .flag_q(flags[i])
    );
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_take_wait;
    (read || write) && waitrequest;
  endsequence

  a_wait_one_cycle: assert property (s_take_wait |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest not low for exactly one cycle");
  a_reserved_zero: assert property (read && waitrequest && regIndex == phy_regs_pkg::REG_RSVD6
    |=> readdata == 32'h0)
    else $error("reserved register read nonzero");
  a_paged_rsvd: assert property (read && waitrequest && regIndex[3]
    && page_q >= phy_regs_pkg::PAGE_RSVD_LO && page_q <= phy_regs_pkg::PAGE_RSVD_HI
    |=> readdata == 32'h0)
    else $error("reserved page read nonzero");
  a_ext_fixed: assert property (read && waitrequest && address == 6'h08
    |=> readdata[7:5] == 3'h7 && readdata[3:0] == (dual_port_strap ? 4'h2 : 4'h1))
    else $error("extended or port field wrong");
  a_speed_fixed: assert property (read && waitrequest && address == 6'h0c
    |=> readdata[7:0] == 8'h41)
    else $error("speed and delay register wrong");
  a_root_clear: assert property (busReset |=> !root_q)
    else $error("root flag survived bus reset");
  a_long_clear: assert property (busReset |=> !longReq_q)
    else $error("long reset request survived bus reset");
  a_busy_holds: assert property (linkBusy && !timerActive |=> !timerActive)
    else $error("bus reset started during traffic");
  a_long_length: assert property (timerStart && longReq_q |=> timerActive [*8])
    else $error("long bus reset ended early");
  a_short_length: assert property (timerStart && !longReq_q
    |=> timerActive [*8] ##19 !timerActive)
    else $error("short bus reset length wrong");
  a_gap_stale: assert property (busReset && !wrStrobe && !configGapValid && stale_q == 2'h1
    |=> gap_q == 6'h3f)
    else $error("gap count not restored after two resets");
  a_power_flag: assert property (cpsPrev_q && !cable_power_sense |=> flags[2])
    else $error("power drop flag not set");
  // Skip the first edge after release, whose flag still holds the reset value
  a_link_active: assert property ($past(rst_n) |->
    linkActiveFlag == $past(linkCtrl_q && link_power_status))
    else $error("link active flag mismatch");
endmodule // phy_base_registers

/* File: common/phy_regs_pkg.sv */
/*
  Constants for the cable PHY base register bank: register indices,
  field positions, fixed field values, reset values and timing counts.
  Assumes a 20 MHz system clock.
*/
package phy_regs_pkg;
  // Register indices; byte address on the bus is four times the index
  localparam logic [3:0] REG_NODE = 4'h0;
  localparam logic [3:0] REG_GAP = 4'h1;
  localparam logic [3:0] REG_EXT = 4'h2;
  localparam logic [3:0] REG_SPEED = 4'h3;
  localparam logic [3:0] REG_LINK = 4'h4;
  localparam logic [3:0] REG_IRQ = 4'h5;
  localparam logic [3:0] REG_RSVD6 = 4'h6;
  localparam logic [3:0] REG_PAGE = 4'h7;
  localparam int IDX_LSB = 2;
  // Bit position 0 of a register is the least significant bit (bit 7 is the MSB here)
  localparam int BIT_ROOT = 1;
  localparam int BIT_CPS = 0;
  localparam int BIT_HOLDOFF = 7;
  localparam int BIT_LONGRST = 6;
  localparam int BIT_LINK_ACTIVE_CONTROL = 7;
  localparam int BIT_CONTEND = 6;
  localparam int BIT_RPIE = 7;
  localparam int BIT_SHORTRST = 6;
  localparam int BIT_CONFIG_TIMEOUT_FLAG = 5;
  localparam int BIT_EAA = 1;
  localparam int BIT_EMC = 0;
  localparam int NUM_FLAGS = 4;
  // Flag order in the flag vector, MSB first as in the register
  localparam int FLAG_CTO = 3;
  localparam int FLAG_PWR = 2;
  localparam int FLAG_STO = 1;
  localparam int FLAG_PORT = 0;
  localparam logic [NUM_FLAGS-1:0] FLAG_RESET = 4'h4;
  // Fixed read-only values, gap count reset value, stale limit and reserved page range
  localparam logic [2:0] EXT_SET = 3'h7;
  localparam logic [3:0] PORTS_TWO = 4'h2;
  localparam logic [3:0] PORTS_ONE = 4'h1;
  localparam logic [2:0] SPEED_S400 = 3'h2;
  localparam logic [3:0] DELAY_CODE = 4'h1;
  localparam logic [2:0] JITTER_CODE = 3'h0;
  localparam logic [5:0] GAP_RESET = 6'h3f;
  localparam logic [1:0] STALE_LIMIT = 2'h2;
  localparam logic [2:0] PAGE_RSVD_LO = 3'h2;
  localparam logic [2:0] PAGE_RSVD_HI = 3'h6;
  // Bus reset durations
  localparam int CLOCK_NS = 50;
  localparam int LONG_RESET_NS = 166000;
  localparam int SHORT_RESET_NS = 1300;
  localparam int TIMER_W = 12;
  localparam logic [TIMER_W-1:0] LONG_CYCLES =
    TIMER_W'((LONG_RESET_NS + CLOCK_NS - 1) / CLOCK_NS);
  localparam logic [TIMER_W-1:0] SHORT_CYCLES =
    TIMER_W'((SHORT_RESET_NS + CLOCK_NS - 1) / CLOCK_NS);
endpackage

/* File: logic/sticky_flag.sv */
/*
  One sticky event flag, cleared by writing one.
  Assumes set and clear are single-cycle strobes in the clock domain.
*/
module sticky_flag #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic setEvent,
  input wire logic clearStrobe,
  output logic flag_q
);
  // Set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag_q <= RESET_VALUE;
    end else if (setEvent) begin
      flag_q <= 1'b1;
    end else if (clearStrobe) begin
      flag_q <= 1'b0;
    end
  end
endmodule // sticky_flag

/* File: logic/bus_reset_timer.sv */
/*
  Times the bus reset the PHY drives, long or short.
  Assumes start is a one-cycle strobe given only while idle.
*/
module bus_reset_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic isShort,
  output logic active_q
);
  logic [phy_regs_pkg::TIMER_W-1:0] count_q;

  // Load the length on start and count down to the end of the reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_q <= '0;
      active_q <= 1'b0;
    end else if (start && !active_q) begin
      count_q <= isShort ? phy_regs_pkg::SHORT_CYCLES : phy_regs_pkg::LONG_CYCLES;
      active_q <= 1'b1;
    end else if (active_q) begin
      count_q <= count_q - 1'b1;
      active_q <= (count_q != 1);
    end
  end
endmodule // bus_reset_timer

/* File: bench/link_master_model.sv */
/*
  Link controller model that reaches the PHY base registers.
  Assumes an Avalon-MM slave with waitrequest on the same clock.
*/
module link_master_model (
  input wire logic clock,
  output logic [5:0] address,
  output logic read,
  output logic write,
  output logic [3:0] byteenable,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial begin
    address = 6'h00;
    read = 1'h0;
    write = 1'h0;
    byteenable = 4'h0;
    writedata = 32'h00000000;
  end

  // One access; held until waitrequest is seen low, no cycle count assumed
  task automatic access(input logic wr, input logic [5:0] a, input logic [3:0] be,
      input logic [7:0] wd, output logic [7:0] rd);
    address <= a;
    byteenable <= be;
    writedata <= {24'h000000, wd};
    read <= !wr;
    write <= wr;
    @(posedge clock);
    while (waitrequest !== 1'h0) @(posedge clock);
    rd = readdata[7:0];
    read <= 1'h0;
    write <= 1'h0;
    writedata <= ~{24'h000000, wd}; // Stale data never lingers on the bus
    @(posedge clock);
  endtask
endmodule // link_master_model

/* File: bench/phy_base_registers_tb.sv */
/*
  Self-checking bench for the PHY base register bank.
  Assumes the link master model as bus master and a 20 MHz clock.
*/
module phy_base_registers_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst_n, read, write, waitrequest;
  logic [5:0] address, selfIdNode, configGap, gapCount;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata;
  logic busResetSeen, selfIdDone, becameRoot, cable_power_sense, dual_port_strap;
  logic [2:0] power_class_straps;
  logic contenderStrap, link_power_status, linkBusy, configGapValid;
  logic configTimeout, stateTimeout, portEvent, resumeStart;
  logic rootHoldoff, linkActiveFlag, nodeIdValid, statusPush;
  logic [7:0] statusData, rv;
  logic busResetDrive, busResetShort, arbAccelEnable;
  int error_cnt, n_tests;
  // Reference state of the bank
  int node, root, hold, lreq, sreq, gap, stale, link_active_control, cont, pwr, flags;
  int rpie, eaa, emc, page, port;
  // Read-only, reserved and paged registers that a write must leave alone
  logic [3:0] roIdx[8] = '{4'h0, 4'h2, 4'h3, 4'h6, 4'h8, 4'ha, 4'hc, 4'hf};

  phy_base_registers phy_base_registers_inst (.clock, .rst_n, .address, .read,
    .write, .byteenable, .writedata, .readdata, .waitrequest, .busResetSeen,
    .selfIdDone, .selfIdNode, .becameRoot, .cable_power_sense, .dual_port_strap,
    .power_class_straps, .contenderStrap, .link_power_status, .linkBusy,
    .configGapValid, .configGap, .configTimeout, .stateTimeout, .portEvent,
    .resumeStart, .gapCount, .rootHoldoff, .linkActiveFlag, .nodeIdValid,
    .statusPush, .statusData, .busResetDrive, .busResetShort, .arbAccelEnable);

  link_master_model link_master_model_inst (.clock, .address, .read, .write,
    .byteenable, .writedata, .readdata, .waitrequest);

  // Free-running system clock
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  // Expected register image from the reference state
  function automatic logic [7:0] expReg(input int i);
    case (i)
      0: return {6'(node), 1'(root), cable_power_sense};
      1: return {1'(hold), 1'(lreq), 6'(gap)};
      2: return dual_port_strap ? 8'he2 : 8'he1;
      3: return 8'h41;
      4: return {1'(link_active_control), 1'(cont), 3'h0, 3'(pwr)};
      5: return {1'(rpie), 1'(sreq), 4'(flags), 1'(eaa), 1'(emc)};
      7: return {3'(page), 1'h0, 4'(port)};
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkCnt(input string n, input int e, input int g);
    n_tests++;
    if (g != e) begin
      error_cnt++;
      $display("wrong value %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic acc(input logic wr, input logic [5:0] a, input logic [3:0] be,
      input logic [7:0] wd);
    link_master_model_inst.access(wr, a, be, wd, rv);
  endtask

  // Register write plus the reference update; requests start at once when idle
  task automatic wreg(input int i, input logic [7:0] v);
    acc(1'h1, {4'(i), 2'h0}, 4'h1, v);
    case (i)
      1: begin hold = v[7]; lreq = v[6]; gap = v[5:0]; stale = 0; end
      4: begin link_active_control = v[7]; cont = v[6]; pwr = v[2:0]; end
      5: begin rpie = v[7]; sreq = v[6]; flags &= ~v[5:2]; eaa = v[1]; emc = v[0]; end
      7: begin page = v[7:5]; port = v[3:0]; end
      default: ;
    endcase
    if (linkBusy === 1'h0 && (lreq != 0 || sreq != 0)) refBusRst();
  endtask

  task automatic checkAll();
    for (int i = 0; i < 16; i++) begin
      acc(1'h0, {4'(i), 2'h0}, 4'h1, 8'h00);
      chk($sformatf("reg%0d", i), expReg(i), rv);
    end
    chk("gapCount", 8'(gap), {2'h0, gapCount});
    chk("rootHoldoff", 8'(hold), {7'h0, rootHoldoff});
    chk("linkActive", 8'(link_active_control & link_power_status), {7'h0, linkActiveFlag});
    chk("arbAccel", 8'(eaa), {7'h0, arbAccelEnable});
  endtask

  // One-cycle event strobe from the PHY core
  task automatic pulse(input int k);
    case (k)
      0: busResetSeen <= 1'h1;
      1: selfIdDone <= 1'h1;
      2: becameRoot <= 1'h1;
      3: configGapValid <= 1'h1;
      4: configTimeout <= 1'h1;
      5: stateTimeout <= 1'h1;
      6: portEvent <= 1'h1;
      default: resumeStart <= 1'h1;
    endcase
    @(posedge clock);
    {busResetSeen, selfIdDone, becameRoot, configGapValid} <= 4'h0;
    {configTimeout, stateTimeout, portEvent, resumeStart} <= 4'h0;
    @(posedge clock);
  endtask

  // Reference effect of any bus reset, seen on the cable or driven by us
  function automatic void refBusRst();
    root = 0;
    lreq = 0;
    sreq = 0;
    stale++;
    if (stale >= 2) begin
      gap = 63;
      stale = 0;
    end
  endfunction

  task automatic busRst();
    pulse(0);
    refBusRst();
  endtask

  // Length in cycles of the bus reset that the bank drives
  task automatic driveLen(input int e, input logic sh);
    int w;
    int n;
    w = 0;
    n = 0;
    while (busResetDrive !== 1'h1 && w < 8) begin @(posedge clock); w++; end
    while (busResetDrive === 1'h1 && n < 4000) begin n++; @(posedge clock); end
    chkCnt("resetCycles", e, n);
    chk("resetShort", {7'h0, sh}, {7'h0, busResetShort});
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Hang guard, well beyond the expected run of some 4500 cycles
  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    results();
  end

  initial begin
    void'($urandom(90757));
    rst_n = 1'h0;
    {busResetSeen, selfIdDone, becameRoot, configGapValid} = 4'h0;
    {configTimeout, stateTimeout, portEvent, resumeStart} = 4'h0;
    selfIdNode = 6'h00;
    configGap = 6'h00;
    linkBusy = 1'h0;
    cable_power_sense = 1'h1;
    dual_port_strap = 1'($urandom);
    power_class_straps = 3'($urandom);
    contenderStrap = 1'($urandom);
    link_power_status = 1'h1;
    {node, root, hold, lreq, sreq, stale, rpie, eaa, emc, page, port} = '0;
    gap = 63;
    link_active_control = 1;
    flags = 4;
    cont = contenderStrap;
    pwr = power_class_straps;
    error_cnt = 0;
    n_tests = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    checkAll();
    // Read-only and reserved places keep their values
    foreach (roIdx[i]) acc(1'h1, {roIdx[i], 2'h0}, 4'h1, 8'hff);
    wreg(7, 8'h00);
    acc(1'h1, 6'h04, 4'he, 8'h00);
    acc(1'h0, 6'h05, 4'h1, 8'h00);
    chk("offLane", 8'h00, rv);
    for (int p = 0; p < 8; p++) begin
      wreg(7, {3'(p), 1'h1, 4'(p + 3)});
      checkAll();
    end
    // Gap count by write, by config packet, and two stale bus resets
    wreg(1, {2'h0, 6'($urandom)});
    busRst();
    checkAll();
    configGap <= 6'($urandom);
    @(posedge clock);
    gap = configGap;
    stale = 0;
    pulse(3);
    busRst();
    checkAll();
    busRst();
    checkAll();
    // Self-identification and root
    chk("nodeValid", 8'h00, {7'h0, nodeIdValid});
    selfIdNode <= 6'($urandom);
    selfIdDone <= 1'h1;
    @(posedge clock);
    node = selfIdNode;
    selfIdDone <= 1'h0;
    @(posedge clock);
    chk("statusPush", 8'h01, {7'h0, statusPush});
    chk("statusData", expReg(0), statusData);
    @(posedge clock);
    chk("pushEnd", 8'h00, {7'h0, statusPush});
    chk("nodeValid", 8'h01, {7'h0, nodeIdValid});
    pulse(2);
    root = 1;
    checkAll();
    busRst();
    checkAll();
    // Event flags, write-one clear, cable power drop, resume enable
    for (int k = 4; k < 7; k++) pulse(k);
    flags = 15;
    checkAll();
    wreg(5, 8'h3c);
    checkAll();
    cable_power_sense <= 1'h0;
    repeat (4) @(posedge clock);
    flags = 4;
    wreg(5, 8'h83);
    pulse(7);
    flags |= 1;
    checkAll();
    // Link control and power class are writable
    link_power_status <= 1'($urandom);
    wreg(4, {1'h0, 1'h1, 3'h7, 3'($urandom)});
    checkAll();
    wreg(4, 8'h80);
    checkAll();
    // Long request held off by traffic, then cancelled by a bus reset
    linkBusy <= 1'h1;
    wreg(1, 8'hc5);
    checkAll();
    chk("heldOff", 8'h00, {7'h0, busResetDrive});
    busRst();
    checkAll();
    wreg(1, 8'h45);
    linkBusy <= 1'h0;
    refBusRst();
    driveLen(int'(phy_regs_pkg::LONG_CYCLES), 1'h0);
    wreg(1, 8'h1a);
    wreg(5, 8'h40);
    driveLen(int'(phy_regs_pkg::SHORT_CYCLES), 1'h1);
    checkAll();
    results();
  end
endmodule // phy_base_registers_tb
